/* design/sps_map.vh */
// register map, field positions, reset values and timing constants of the phase sequencer
`ifndef SPS_MAP_VH
`define SPS_MAP_VH
// register byte addresses
`define SPS_ADDR_CTRL 4'h0
`define SPS_ADDR_STATUS 4'h4
`define SPS_ADDR_IRQ_STAT 4'h8
`define SPS_ADDR_IRQ_MASK 4'hC
// control fields
`define SPS_CTRL_HALF_BIT 0
`define SPS_CTRL_DIR_BIT 1
`define SPS_CTRL_RST_BIT 2
`define SPS_CTRL_RESET 3'h3
// event bits in irq status and mask
`define SPS_EV_STEP 0
`define SPS_EV_FAULT 1
`define SPS_EV_RESUME 2
`define SPS_EV_W 3
// home state index, states counted 0..7 for printed 1..8
`define SPS_HOME_STATE 3'h0
// timing
`define SPS_CLK_HZ 25000000
`define SPS_OFF_TIME_US 400
`define SPS_OFF_CYCLES ((`SPS_OFF_TIME_US * (`SPS_CLK_HZ / 1000000)))
`endif

/* design/sps_sync.v */
// three-stage input synchroniser with second/third agreement
`timescale 1ns/100ps
`default_nettype none
module sps_sync #(
   parameter WIDTH = 1
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire [WIDTH-1:0] i_async,
   output reg [WIDTH-1:0] o_sync
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   genvar g;
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         stage1 <= {WIDTH{1'b0}};
         stage2 <= {WIDTH{1'b0}};
         stage3 <= {WIDTH{1'b0}};
      end else begin
         stage1 <= i_async;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end
   // a bit changes only once two late stages agree, filtering a single-cycle glitch
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_agree
         always @(posedge i_clk) begin
            if (!i_rst_n) begin
               o_sync[g] <= 1'b0;
            end else if (stage2[g] == stage3[g]) begin
               o_sync[g] <= stage3[g];
            end
         end
      end
   endgenerate
endmodule // sps_sync
`default_nettype wire

/* design/sps_sequencer.v */
// two-phase stepper phase sequencer with overcurrent off-time and register port
`timescale 1ns/100ps
`default_nettype none
`include "sps_map.vh"

// Summary of operation
// - the state advances on each rising step-clock edge and never on a falling one.
// - reset, at power-up or from the reset input, puts the sequencer in home state 1.
// - a high step-size select gives half step mode over all eight states.
// - half step moves one state per edge, up 1..8 for direction high, down 1,8,7..2 for low, wrapping.
// - direction high means clockwise ascending, low means counterclockwise descending.
// - step-size select low in an odd state gives normal full step drive.
// - normal drive steps by two through 1,3,5,7 up or 1,7,5,3 down.
// - normal drive energises both phases in every state, wave drive exactly one.
// - step-size select low in an even state gives wave full step drive.
// - wave drive steps by two through 2,4,6,8 up or 8,6,4,2 down.
// - one half-step pulse from home goes to state 2 for direction high, to state 8 for low.
// - phase polarity and enable of both bridges are decoded from the current state.
// - an overcurrent detection flags a fault and forces the bridge enable low, both bridges off.
// - after a fault the bridges stay off for about 400 us, then resume by themselves.
module sps_sequencer #(
   parameter OFF_CYCLES = `SPS_OFF_CYCLES
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_step_clock,
   input wire i_rotation_direction,
   input wire i_half_step,
   input wire i_seq_reset_n,
   input wire i_overcurrent_detector,
   input wire [3:0] i_addr,
   input wire [31:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [31:0] o_rdata,
   output reg o_phase_a,
   output reg o_enable_a,
   output reg o_phase_b,
   output reg o_enable_b,
   output reg o_bridge_enable,
   output reg o_fault,
   output wire o_irq
);
   //------------------------------------------------------------
   // pin synchronisers
   //------------------------------------------------------------
   wire [4:0] pins_sync;
   wire step_s;
   wire dir_pin;
   wire half_pin;
   wire rst_pin_n;
   wire ocp_s;
   sps_sync #(
      .WIDTH(5)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_async({i_overcurrent_detector, i_seq_reset_n, i_half_step, i_rotation_direction, i_step_clock}),
      .o_sync(pins_sync)
   );
   assign step_s = pins_sync[0];
   assign dir_pin = pins_sync[1];
   assign half_pin = pins_sync[2];
   // synchroniser resets to zero, so the pin reset holds the sequencer at home until it settles
   assign rst_pin_n = pins_sync[3];
   assign ocp_s = pins_sync[4];

   //------------------------------------------------------------
   // registers
   //------------------------------------------------------------
   reg [2:0] ctrl;
   reg [2:0] irq_stat;
   reg [2:0] irq_mask;
   reg step_prev;
   reg [2:0] state;
   reg [2:0] next_state;
   // a full-width count lets the off time be set for any clock rate
   reg [31:0] off_count;
   reg ocp_prev;

   wire use_reg_mode;
   wire half_sel;
   wire dir_sel;
   wire seq_clear;
   wire step_rise;
   wire fault_start;
   wire fault_end;
   wire wr_irq_stat;
   wire wr_ctrl;
   wire wr_irq_mask;

   // ctrl bit 2 hands half/direction over to software; pins rule otherwise
   assign use_reg_mode = ctrl[`SPS_CTRL_RST_BIT];
   assign half_sel = use_reg_mode ? ctrl[`SPS_CTRL_HALF_BIT] : half_pin;
   assign dir_sel = use_reg_mode ? ctrl[`SPS_CTRL_DIR_BIT] : dir_pin;
   assign seq_clear = !rst_pin_n;
   assign step_rise = step_s && !step_prev;
   assign fault_start = ocp_s && !ocp_prev && !o_fault;
   assign fault_end = o_fault && (off_count == 32'h00000001);
   assign wr_irq_stat = i_wr && (i_addr == `SPS_ADDR_IRQ_STAT);
   // unmapped addresses fall through: writes vanish and reads give zero
   assign wr_ctrl = i_wr && (i_addr == `SPS_ADDR_CTRL);
   assign wr_irq_mask = i_wr && (i_addr == `SPS_ADDR_IRQ_MASK);

   //------------------------------------------------------------
   // state sequence
   //------------------------------------------------------------
   always @* begin
      next_state = state;
      // three-bit arithmetic wraps the last state back to home for free
      if (half_sel) begin
         // half step: one state per edge
         next_state = dir_sel ? state + 3'h1 : state - 3'h1;
      end else begin
         // full step: two per edge keeps parity, so odd stays normal and even stays wave
         next_state = dir_sel ? state + 3'h2 : state - 3'h2;
      end
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         state <= `SPS_HOME_STATE;
         step_prev <= 1'b1;
      end else begin
         // held high through a pin reset so a step pin idling high gives no false edge after it
         step_prev <= seq_clear ? 1'b1 : step_s;
         if (seq_clear) begin
            state <= `SPS_HOME_STATE;
         end else if (step_rise) begin
            state <= next_state;
         end
      end
   end

   //------------------------------------------------------------
   // bridge decode
   //------------------------------------------------------------
   // states index 0..7 = printed 1..8; odd printed states have both phases on
   reg next_phase_a;
   reg next_enable_a;
   reg next_phase_b;
   reg next_enable_b;

   always @* begin
      next_phase_a = 1'b1;
      next_enable_a = 1'b1;
      next_phase_b = 1'b1;
      next_enable_b = 1'b1;
      case (state)
         3'h0: begin
            next_phase_a = 1'b1;
            next_enable_a = 1'b1;
            next_phase_b = 1'b1;
            next_enable_b = 1'b1;
         end
         3'h1: begin
            next_phase_a = 1'b1;
            next_enable_a = 1'b0;
            next_phase_b = 1'b1;
            next_enable_b = 1'b1;
         end
         3'h2: begin
            next_phase_a = 1'b0;
            next_enable_a = 1'b1;
            next_phase_b = 1'b1;
            next_enable_b = 1'b1;
         end
         3'h3: begin
            next_phase_a = 1'b0;
            next_enable_a = 1'b1;
            next_phase_b = 1'b1;
            next_enable_b = 1'b0;
         end
         3'h4: begin
            next_phase_a = 1'b0;
            next_enable_a = 1'b1;
            next_phase_b = 1'b0;
            next_enable_b = 1'b1;
         end
         3'h5: begin
            next_phase_a = 1'b0;
            next_enable_a = 1'b0;
            next_phase_b = 1'b0;
            next_enable_b = 1'b1;
         end
         3'h6: begin
            next_phase_a = 1'b1;
            next_enable_a = 1'b1;
            next_phase_b = 1'b0;
            next_enable_b = 1'b1;
         end
         3'h7: begin
            next_phase_a = 1'b1;
            next_enable_a = 1'b1;
            next_phase_b = 1'b0;
            next_enable_b = 1'b0;
         end
         default: begin
            next_phase_a = 1'b1;
            next_enable_a = 1'b1;
            next_phase_b = 1'b1;
            next_enable_b = 1'b1;
         end
      endcase
   end

   // registered so the bridge controls never glitch while the state bits change together
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_phase_a <= 1'b1;
         o_enable_a <= 1'b1;
         o_phase_b <= 1'b1;
         o_enable_b <= 1'b1;
      end else begin
         o_phase_a <= next_phase_a;
         o_enable_a <= next_enable_a;
         o_phase_b <= next_phase_b;
         o_enable_b <= next_enable_b;
      end
   end

   //------------------------------------------------------------
   // overcurrent off time
   //------------------------------------------------------------
   // the count restarts only on a new detection after recovery; a held fault needs a fresh rising edge to retrigger
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_fault <= 1'b0;
         o_bridge_enable <= 1'b1;
         off_count <= 32'h00000000;
         ocp_prev <= 1'b0;
      end else begin
         ocp_prev <= ocp_s;
         if (fault_start) begin
            o_fault <= 1'b1;
            o_bridge_enable <= 1'b0;
            off_count <= OFF_CYCLES;
         end else if (fault_end) begin
            o_fault <= 1'b0;
            o_bridge_enable <= 1'b1;
            off_count <= 32'h00000000;
         end else if (o_fault) begin
            off_count <= off_count - 32'h00000001;
         end
      end
   end

   //------------------------------------------------------------
   // register port and interrupt
   //------------------------------------------------------------
   wire [2:0] events;
   reg [2:0] next_irq_stat;
   reg [31:0] next_rdata;
   assign events = {fault_end, fault_start, step_rise && !seq_clear};

   // a new event wins over a write-one clear in the same cycle
   always @* begin
      next_irq_stat = irq_stat;
      if (wr_irq_stat) begin
         next_irq_stat = irq_stat & ~i_wdata[2:0];
      end
      next_irq_stat = next_irq_stat | events;
   end

   // read data live for one cycle only and are zero otherwise
   always @* begin
      next_rdata = 32'h00000000;
      if (i_rd) begin
         case (i_addr)
            `SPS_ADDR_CTRL: next_rdata = {29'h00000000, ctrl};
            `SPS_ADDR_STATUS: next_rdata = {24'h000000, half_sel, dir_sel, o_bridge_enable, o_fault, 1'b0, state};
            `SPS_ADDR_IRQ_STAT: next_rdata = {29'h00000000, irq_stat};
            `SPS_ADDR_IRQ_MASK: next_rdata = {29'h00000000, irq_mask};
            default: next_rdata = 32'h00000000;
         endcase
      end
   end

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctrl <= `SPS_CTRL_RESET;
         irq_mask <= 3'h0;
         irq_stat <= 3'h0;
         o_rdata <= 32'h00000000;
      end else begin
         if (wr_ctrl) begin
            ctrl <= i_wdata[2:0];
         end
         if (wr_irq_mask) begin
            irq_mask <= i_wdata[2:0];
         end
         irq_stat <= next_irq_stat;
         o_rdata <= next_rdata;
      end
   end

   // level interrupt: stays up until software clears every unmasked event
   assign o_irq = |(irq_stat & irq_mask);
endmodule // sps_sequencer
`default_nettype wire

/* sim/sps_sequencer_monitor.sv */
// port checker of the phase sequencer
`timescale 1ns/100ps
`default_nettype none
module sps_sequencer_monitor #(
   parameter OFF_CYCLES = 8
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_step_clock,
   input wire logic i_seq_reset_n,
   input wire logic i_overcurrent_detector,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic o_phase_a,
   input wire logic o_enable_a,
   input wire logic o_phase_b,
   input wire logic o_enable_b,
   input wire logic o_bridge_enable,
   input wire logic o_fault
);
   default clocking @(posedge i_clk); endclocking
   logic [3:0] outs;
   logic [15:0] fcnt;
   logic [3:0] quiet;
   assign outs = {o_phase_a, o_enable_a, o_phase_b, o_enable_b};
   // quiet saturates so a long idle spell never wraps back into the allowed window
   always @(posedge i_clk) begin
      fcnt <= (!i_rst_n || !o_fault) ? 16'h0 : fcnt + 16'h1;
      quiet <= (!i_rst_n || i_step_clock) ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
   end
   a_fault_bridge: assert property (disable iff (!i_rst_n) o_fault != o_bridge_enable)
      else $error("fault flag and bridge enable disagree");
   a_fault_start: assert property (disable iff (!i_rst_n)
      ($rose(i_overcurrent_detector) && !o_fault) |-> ##[1:8] o_fault) else $error("no fault after detection");
   a_offtime_len: assert property (disable iff (!i_rst_n) $fell(o_fault) |-> fcnt == OFF_CYCLES)
      else $error("off time of wrong length");
   a_offtime_cap: assert property (disable iff (!i_rst_n) o_fault |-> fcnt < OFF_CYCLES)
      else $error("off time overran");
   a_never_dark: assert property (disable iff (!i_rst_n) o_enable_a || o_enable_b)
      else $error("both bridges disabled by state");
   a_quiet_hold: assert property (disable iff (!i_rst_n)
      (!$stable(outs) && i_seq_reset_n && $past(i_seq_reset_n, 8)) |-> quiet < 4'h3) else $error("moved without step");
   a_step_moves: assert property (disable iff (!i_rst_n)
      ($rose(i_step_clock) && i_seq_reset_n && $past(i_seq_reset_n, 8)) |-> ##[3:9] !$stable(outs))
      else $error("step edge ignored");
   a_reset_home: assert property (!i_rst_n |=> (outs == 4'hF && o_bridge_enable && !o_fault))
      else $error("reset did not give home");
   a_rdata_idle: assert property (disable iff (!i_rst_n) !$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data outside its cycle");
endmodule // sps_sequencer_monitor
`default_nettype wire

/* sim/sps_host_model.sv */
// controller model driving step, direction, mode, reset and fault pins
`timescale 1ns/100ps
`default_nettype none
module sps_host_model (
   input wire logic i_clk,
   output logic o_step_clock,
   output logic o_rotation_direction,
   output logic o_half_step,
   output logic o_seq_reset_n,
   output logic o_overcurrent_detector
);
   // levels standing in for the two analog phase current references
   logic [5:0] phase_a_current_reference;
   logic [5:0] phase_b_current_reference;
   initial begin
      o_step_clock = 1'b0;
      o_rotation_direction = 1'b1;
      o_half_step = 1'b1;
      o_seq_reset_n = 1'b1;
      o_overcurrent_detector = 1'b0;
      phase_a_current_reference = 6'h00;
      phase_b_current_reference = 6'h00;
   end
   // long high phase so the state moves while the pin is still high
   task automatic step_pulse;
      @(posedge i_clk) o_step_clock <= 1'b1;
      repeat (8) @(posedge i_clk);
      o_step_clock <= 1'b0;
      repeat (6) @(posedge i_clk);
   endtask
   // one step period with both references ramped through 64 levels, a up and b down
   task automatic micro_step;
      @(posedge i_clk) o_step_clock <= 1'b1;
      for (int k = 0; k < 64; k++) begin
         @(posedge i_clk) begin
            phase_a_current_reference <= 6'(k);
            phase_b_current_reference <= 6'(63 - k);
         end
         if (k == 8) o_step_clock <= 1'b0;
      end
   endtask
   task automatic set_mode(input logic half, input logic dir);
      @(posedge i_clk) begin
         o_half_step <= half;
         o_rotation_direction <= dir;
      end
      repeat (6) @(posedge i_clk);
   endtask
   task automatic home;
      @(posedge i_clk) o_seq_reset_n <= 1'b0;
      repeat (8) @(posedge i_clk);
      o_seq_reset_n <= 1'b1;
      repeat (8) @(posedge i_clk);
   endtask
   task automatic fault_pulse;
      @(posedge i_clk) o_overcurrent_detector <= 1'b1;
      repeat (6) @(posedge i_clk);
      o_overcurrent_detector <= 1'b0;
   endtask
endmodule // sps_host_model
`default_nettype wire

/* sim/sps_sequencer_bench.sv */
// self-checking bench of the phase sequencer
`timescale 1ns/100ps
`default_nettype none
`include "sps_map.vh"
module sps_sequencer_bench;
   logic clk, rst_n, wr, rd, stp, dir, half, srst_n, ovc, pha, ena, phb, enb, bren, flt, irq;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, d;
   int miscompares = 0;
   int num_checks = 0;
   int n;
   sps_sequencer #(.OFF_CYCLES(8)) i_sps_sequencer (.i_clk(clk), .i_rst_n(rst_n), .i_step_clock(stp),
      .i_rotation_direction(dir), .i_half_step(half), .i_seq_reset_n(srst_n), .i_overcurrent_detector(ovc),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_phase_a(pha), .o_enable_a(ena),
      .o_phase_b(phb), .o_enable_b(enb), .o_bridge_enable(bren), .o_fault(flt), .o_irq(irq));
   sps_host_model i_sps_host_model (.i_clk(clk), .o_step_clock(stp), .o_rotation_direction(dir),
      .o_half_step(half), .o_seq_reset_n(srst_n), .o_overcurrent_detector(ovc));
   task automatic close_out;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk) begin
         addr <= a;
         wdata <= v;
         wr <= 1'b1;
      end
      @(posedge clk) wr <= 1'b0;
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk) begin
         addr <= a;
         rd <= 1'b1;
      end
      @(posedge clk) rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic see(input logic [2:0] s);
      logic ea, eb;
      ea = s != 3'h1 && s != 3'h5;
      eb = s != 3'h3 && s != 3'h7;
      rd_reg(`SPS_ADDR_STATUS);
      chk(d[2:0], s);
      chk({pha & ena, ena, phb & enb, enb}, {ea & (s == 3'h0 || s > 3'h5), ea, eb & (s < 3'h3), eb});
   endtask
   task automatic t_half;
      i_sps_host_model.set_mode(1'b1, 1'b1);
      i_sps_host_model.home();
      see(3'h0);
      for (int k = 1; k <= 8; k++) begin
         i_sps_host_model.step_pulse();
         see(3'(k));
      end
      i_sps_host_model.set_mode(1'b1, 1'b0);
      for (int k = 1; k <= 8; k++) begin
         i_sps_host_model.step_pulse();
         see(3'(8 - k));
      end
   endtask
   task automatic t_normal;
      i_sps_host_model.set_mode(1'b0, 1'b1);
      i_sps_host_model.home();
      for (int k = 1; k <= 4; k++) begin
         i_sps_host_model.step_pulse();
         see(3'(2 * k));
      end
      i_sps_host_model.set_mode(1'b0, 1'b0);
      for (int k = 1; k <= 4; k++) begin
         i_sps_host_model.step_pulse();
         see(3'(8 - 2 * k));
      end
      i_sps_host_model.micro_step();
      see(3'h6);
      chk({i_sps_host_model.phase_a_current_reference, i_sps_host_model.phase_b_current_reference}, 32'hFC0);
      i_sps_host_model.set_mode(1'b1, 1'b1);
      see(3'h6);
   endtask
   task automatic t_wave;
      i_sps_host_model.set_mode(1'b1, 1'b0);
      i_sps_host_model.home();
      i_sps_host_model.step_pulse();
      see(3'h7);
      i_sps_host_model.set_mode(1'b0, 1'b0);
      for (int k = 1; k <= 4; k++) begin
         i_sps_host_model.step_pulse();
         see(3'(7 - 2 * k));
      end
      i_sps_host_model.set_mode(1'b0, 1'b1);
      for (int k = 1; k <= 4; k++) begin
         i_sps_host_model.step_pulse();
         see(3'(7 + 2 * k));
      end
   endtask
   // a wait that used up its bound is a mismatch and ends the run
   task automatic timed_out;
      if (n == 40) begin
         miscompares++;
         close_out();
      end
   endtask
   task automatic t_fault;
      wr_reg(`SPS_ADDR_IRQ_MASK, 32'h2);
      wr_reg(`SPS_ADDR_IRQ_STAT, 32'h7);
      chk(irq, 1'b0);
      i_sps_host_model.fault_pulse();
      for (n = 0; n < 40 && flt !== 1'b1; n++) @(posedge clk);
      timed_out();
      chk({flt, bren, irq}, 3'b101);
      rd_reg(`SPS_ADDR_IRQ_STAT);
      chk(d[1], 1'b1);
      for (n = 0; n < 40 && bren !== 1'b1; n++) @(posedge clk);
      timed_out();
      chk({flt, bren}, 2'b01);
      wr_reg(`SPS_ADDR_IRQ_STAT, 32'h2);
      chk(irq, 1'b0);
      rd_reg(4'h2);
      chk(d, 32'h0);
   endtask
   // power reset in mid-run, away from home
   task automatic t_reset;
      @(posedge clk) rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      see(3'h0);
      chk({bren, flt, irq}, 3'b100);
   endtask
   // software takes mode and direction over from the pins
   task automatic t_soft;
      wr_reg(`SPS_ADDR_IRQ_MASK, 32'h1);
      wr_reg(`SPS_ADDR_CTRL, 32'h7);
      rd_reg(`SPS_ADDR_CTRL);
      chk(d, 32'h7);
      see(3'h0);
      i_sps_host_model.step_pulse();
      see(3'h1);
      chk(irq, 1'b1);
      wr_reg(`SPS_ADDR_CTRL, 32'h4);
      i_sps_host_model.step_pulse();
      see(3'h7);
      wr_reg(`SPS_ADDR_IRQ_STAT, 32'h7);
      chk(irq, 1'b0);
      wr_reg(`SPS_ADDR_CTRL, 32'h3);
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_half();
      t_normal();
      t_wave();
      t_fault();
      t_reset();
      t_soft();
      close_out();
   end
endmodule // sps_sequencer_bench
bind sps_sequencer sps_sequencer_monitor #(.OFF_CYCLES(OFF_CYCLES)) i_sps_sequencer_monitor (.i_clk(i_clk),
   .i_rst_n(i_rst_n), .i_step_clock(i_step_clock), .i_seq_reset_n(i_seq_reset_n), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_overcurrent_detector(i_overcurrent_detector), .o_phase_a(o_phase_a), .o_enable_a(o_enable_a),
   .o_phase_b(o_phase_b), .o_enable_b(o_enable_b), .o_bridge_enable(o_bridge_enable), .o_fault(o_fault));
`default_nettype wire
